//--- pkg/dss_pkg.sv
// Purpose: Constants for the demodulator status snapshot register bank.
// Assumes: Classic Wishbone, 32-bit data, one register per aligned word.
// Notes: Register indices are word offsets of the bank; bus byte address is four times.
package dss_pkg;

    localparam int ADR_W = 10;
    localparam int DAT_W = 32;
    localparam int IDX_W = 8;
    localparam int VAL_W = 20;

    // Register indices
    localparam logic [7:0] IDX_SNAP_CTRL = 8'h25;
    localparam logic [7:0] IDX_PILOT_LOW = 8'h34;
    localparam logic [7:0] IDX_PILOT_MID = 8'h35;
    localparam logic [7:0] IDX_PILOT_TOP = 8'h36;
    localparam logic [7:0] IDX_ERR_LOW = 8'h39;
    localparam logic [7:0] IDX_ERR_MID = 8'h3A;
    localparam logic [7:0] IDX_ERR_TOP = 8'h3B;
    localparam logic [7:0] IDX_LOOP_LOW = 8'h3C;
    localparam logic [7:0] IDX_LOOP_MID = 8'h3D;
    localparam logic [7:0] IDX_LOOP_TOP = 8'h3E;
    localparam logic [7:0] IDX_FEC_SYNC = 8'h41;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h70;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h71;

    // Field positions
    localparam int SNAP_TRIG_BIT = 0;
    localparam int FEC_SYNC_LSB = 0;
    localparam int DEINT_LSB = 2;
    localparam int TRELLIS_LSB = 6;

    // Encodings
    localparam logic [1:0] FEC_SEARCH = 2'h0;
    localparam logic [1:0] FEC_LOCKED = 2'h1;
    localparam logic [1:0] FEC_LOST = 2'h3;
    localparam logic [1:0] TRL_LOCK_LOW = 2'h0;
    localparam logic [1:0] TRL_LOCK_HIGH = 2'h2;
    localparam logic [1:0] TRL_HUNT = 2'h3;

    // Interrupt status bits
    localparam int IRQ_N = 3;
    localparam int IRQ_SNAP = 0;
    localparam int IRQ_FEC_LOCK = 1;
    localparam int IRQ_FEC_LOST = 2;

    // Reset values
    localparam logic [VAL_W-1:0] VAL_RST = 20'h0_0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [IRQ_N-1:0] IRQ_RST = 3'h0;
    localparam logic [DAT_W-1:0] DAT_RST = 32'h0000_0000;

endpackage : dss_pkg

//--- verilog/dss_status_regs.sv
// Purpose: Status snapshot bank of a VSB/QAM demodulator on classic Wishbone, read-only except the trigger and mask words.
// Assumes: Loop values and sync states arrive synchronous to i_ref_clk.
// Notes: Multi-byte values change only on the snapshot trigger; the FEC byte is live.
//
// Overview of operation
// [RULE1] Pilot accumulator bits 19:16 in top byte
// [RULE2] Pilot low and middle bytes in two registers
// [RULE3] Average error split into three byte registers
// [RULE4] QAM loop accumulator split into three registers
// [RULE5] Snapshot refreshes only on trigger bit write
// [RULE6] FEC sync state in bits 1:0
// [RULE7] QAM trellis sync state in bits 7:6
// [RULE8] QAM deinterleaver work value in bits 5:2
// [RULE9] Top byte upper nibble reads zero
// [RULE10] All bytes captured in same cycle
`timescale 1ns/1ps

module dss_status_regs (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [dss_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [dss_pkg::DAT_W-1:0] i_wb_dat,
    output logic [dss_pkg::DAT_W-1:0] o_wb_dat,
    output logic o_wb_ack,
    output logic o_irq,
    input wire logic i_qam_mode,
    input wire logic [dss_pkg::VAL_W-1:0] i_pilot_acc,
    input wire logic [dss_pkg::VAL_W-1:0] i_avg_err,
    input wire logic [dss_pkg::VAL_W-1:0] i_loop_acc,
    input wire logic [1:0] i_fec_sync,
    input wire logic [1:0] i_trellis_sync,
    input wire logic [3:0] i_deint_work
);

    typedef struct packed {
        logic [dss_pkg::VAL_W-1:0] pilot;
        logic [dss_pkg::VAL_W-1:0] err;
        logic [dss_pkg::VAL_W-1:0] loop;
        logic [7:0] fec;
        logic [1:0] fec_prev;
        logic [dss_pkg::IRQ_N-1:0] irq_stat;
        logic [dss_pkg::IRQ_N-1:0] irq_mask;
        logic [dss_pkg::DAT_W-1:0] dat;
        logic ack;
        logic irq;
    } dss_state_t;

    dss_state_t st_r;
    dss_state_t st_nxt;
    logic [1:0] rst_sync_r;
    logic rst_b;

    // Release is synchronous so no flop sees a partial reset edge
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_r[1];

    // Byte slice of a 20-bit value; top slice keeps only four bits
    function automatic logic [7:0] dss_slice(input logic [dss_pkg::VAL_W-1:0] v,
                                             input logic [1:0] part);
        logic [7:0] b;
        b = 8'h00;
        unique case (part)
            2'h0: b = v[7:0];
            2'h1: b = v[15:8];
            2'h2: b = {4'h0, v[19:16]}; // RULE9
            default: b = 8'h00;
        endcase
        return b;
    endfunction : dss_slice

    // Live FEC status byte, mode dependent
    function automatic logic [7:0] dss_fec_byte(input logic qam, input logic [1:0] fs,
                                                input logic [1:0] ts, input logic [3:0] dw);
        logic [7:0] b;
        b = 8'h00;
        b[dss_pkg::FEC_SYNC_LSB +: 2] = fs; // RULE6
        if (qam) begin
            b[dss_pkg::TRELLIS_LSB +: 2] = ts; // RULE7
            b[dss_pkg::DEINT_LSB +: 4] = dw; // RULE8
        end
        return b;
    endfunction : dss_fec_byte

    // Write strobe for one word; every field of this bank sits in lane 0
    function automatic logic dss_wr_hit(
        input logic rq,
        input logic we,
        input logic [3:0] sel,
        input logic [dss_pkg::IDX_W-1:0] at,
        input logic [dss_pkg::IDX_W-1:0] want
    );
        logic hit;
        hit = 1'b0;
        if (rq && we && sel[0]) begin
            if (at == want) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : dss_wr_hit

    // Read strobe for one word; lanes do not matter for a read
    function automatic logic dss_rd_hit(
        input logic rq,
        input logic we,
        input logic [dss_pkg::IDX_W-1:0] at,
        input logic [dss_pkg::IDX_W-1:0] want
    );
        logic hit;
        hit = 1'b0;
        if (rq && !we) begin
            if (at == want) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : dss_rd_hit

    // Only a one in the trigger bit refreshes; a zero write is a no-op
    function automatic logic dss_trig_hit(
        input logic hit,
        input logic [dss_pkg::DAT_W-1:0] wdat
    );
        logic t;
        t = 1'b0;
        if (hit && wdat[dss_pkg::SNAP_TRIG_BIT]) begin
            t = 1'b1;
        end
        return t;
    endfunction : dss_trig_hit

    // Pulse on entry into a sync code, not while the code persists
    function automatic logic dss_entered(
        input logic [1:0] cur,
        input logic [1:0] prev,
        input logic [1:0] code
    );
        logic hit;
        hit = 1'b0;
        if ((cur == code) && (prev != code)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : dss_entered

    // Events in the layout of the status and mask words
    function automatic logic [dss_pkg::IRQ_N-1:0] dss_events(
        input logic snap,
        input logic [1:0] cur,
        input logic [1:0] prev
    );
        logic [dss_pkg::IRQ_N-1:0] e;
        e = dss_pkg::IRQ_RST;
        e[dss_pkg::IRQ_SNAP] = snap;
        e[dss_pkg::IRQ_FEC_LOCK] = dss_entered(cur, prev, dss_pkg::FEC_LOCKED);
        e[dss_pkg::IRQ_FEC_LOST] = dss_entered(cur, prev, dss_pkg::FEC_LOST);
        return e;
    endfunction : dss_events

    // Clear first, then set: an event in the clearing cycle survives
    function automatic logic [dss_pkg::IRQ_N-1:0] dss_sticky(
        input logic clr,
        input logic [dss_pkg::IRQ_N-1:0] held,
        input logic [dss_pkg::IRQ_N-1:0] set
    );
        logic [dss_pkg::IRQ_N-1:0] s;
        s = held;
        if (clr) begin
            s = dss_pkg::IRQ_RST;
        end
        s = s | set;
        return s;
    endfunction : dss_sticky

    // Mask takes lane 0 of a write; a read leaves it alone
    function automatic logic [dss_pkg::IRQ_N-1:0] dss_mask_next(
        input logic wr,
        input logic [dss_pkg::IRQ_N-1:0] held,
        input logic [dss_pkg::DAT_W-1:0] wdat
    );
        logic [dss_pkg::IRQ_N-1:0] m;
        m = held;
        if (wr) begin
            m = wdat[dss_pkg::IRQ_N-1:0];
        end
        return m;
    endfunction : dss_mask_next

    // Level request while any unmasked status bit is set
    function automatic logic dss_irq_level(
        input logic [dss_pkg::IRQ_N-1:0] stat,
        input logic [dss_pkg::IRQ_N-1:0] mask
    );
        logic lvl;
        lvl = 1'b0;
        if ((stat & mask) != dss_pkg::IRQ_RST) begin
            lvl = 1'b1;
        end
        return lvl;
    endfunction : dss_irq_level

    // Interrupt words are three bits wide; the rest reads zero
    function automatic logic [7:0] dss_irq_byte(
        input logic [dss_pkg::IRQ_N-1:0] bits
    );
        logic [7:0] b;
        b = dss_pkg::BYTE_RST;
        b[dss_pkg::IRQ_N-1:0] = bits;
        return b;
    endfunction : dss_irq_byte

    // Read byte of one word; unmapped words and the trigger word read zero
    function automatic logic [7:0] dss_rd_mux(
        input dss_state_t s,
        input logic [dss_pkg::IDX_W-1:0] at
    );
        logic [7:0] b;
        b = dss_pkg::BYTE_RST;
        unique case (at)
            dss_pkg::IDX_PILOT_LOW: b = dss_slice(s.pilot, 2'h0); // RULE2
            dss_pkg::IDX_PILOT_MID: b = dss_slice(s.pilot, 2'h1); // RULE2
            dss_pkg::IDX_PILOT_TOP: b = dss_slice(s.pilot, 2'h2); // RULE1
            dss_pkg::IDX_ERR_LOW: b = dss_slice(s.err, 2'h0); // RULE3
            dss_pkg::IDX_ERR_MID: b = dss_slice(s.err, 2'h1); // RULE3
            dss_pkg::IDX_ERR_TOP: b = dss_slice(s.err, 2'h2); // RULE3
            dss_pkg::IDX_LOOP_LOW: b = dss_slice(s.loop, 2'h0); // RULE4
            dss_pkg::IDX_LOOP_MID: b = dss_slice(s.loop, 2'h1); // RULE4
            dss_pkg::IDX_LOOP_TOP: b = dss_slice(s.loop, 2'h2); // RULE4
            dss_pkg::IDX_FEC_SYNC: b = s.fec;
            dss_pkg::IDX_IRQ_STAT: b = dss_irq_byte(s.irq_stat);
            dss_pkg::IDX_IRQ_MASK: b = dss_irq_byte(s.irq_mask);
            default: b = dss_pkg::BYTE_RST;
        endcase
        return b;
    endfunction : dss_rd_mux

    // Hold a snapshot unless the trigger fires in this cycle
    function automatic logic [dss_pkg::VAL_W-1:0] dss_snap(
        input logic hit,
        input logic [dss_pkg::VAL_W-1:0] held,
        input logic [dss_pkg::VAL_W-1:0] live
    );
        logic [dss_pkg::VAL_W-1:0] v;
        v = held;
        if (hit) begin
            v = live;
        end
        return v;
    endfunction : dss_snap

    // Bus word from one register byte; upper lanes always read zero
    function automatic logic [dss_pkg::DAT_W-1:0] dss_word(
        input logic [7:0] b
    );
        logic [dss_pkg::DAT_W-1:0] w;
        w = dss_pkg::DAT_RST;
        w[7:0] = b;
        return w;
    endfunction : dss_word

    // Read answers carry the byte; write answers carry zero
    function automatic logic [dss_pkg::DAT_W-1:0] dss_answer(
        input logic rq,
        input logic we,
        input logic [dss_pkg::DAT_W-1:0] held,
        input logic [7:0] b
    );
        logic [dss_pkg::DAT_W-1:0] w;
        w = held;
        if (rq) begin
            if (!we) begin
                w = dss_word(b);
            end else begin
                w = dss_pkg::DAT_RST;
            end
        end
        return w;
    endfunction : dss_answer

    logic req;
    logic [dss_pkg::IDX_W-1:0] idx;
    logic trig;
    logic stat_rd;
    logic mask_wr;
    logic [7:0] rd_byte;
    logic [dss_pkg::IRQ_N-1:0] ev;

    always_comb begin
        st_nxt = st_r;

        // A request is taken only while ack is low, so each one counts once
        req = i_wb_cyc && i_wb_stb && !st_r.ack;
        idx = i_wb_adr[dss_pkg::ADR_W-1:2];
        trig = dss_trig_hit(dss_wr_hit(req, i_wb_we, i_wb_sel, idx, dss_pkg::IDX_SNAP_CTRL),
            i_wb_dat);
        stat_rd = dss_rd_hit(req, i_wb_we, idx, dss_pkg::IDX_IRQ_STAT);
        mask_wr = dss_wr_hit(req, i_wb_we, i_wb_sel, idx, dss_pkg::IDX_IRQ_MASK);
        rd_byte = dss_rd_mux(st_r, idx);

        // Whole values in one edge, so bytes read later agree
        st_nxt.pilot = dss_snap(trig, st_r.pilot, i_pilot_acc); // RULE5 RULE10
        st_nxt.err = dss_snap(trig, st_r.err, i_avg_err); // RULE5 RULE10
        st_nxt.loop = dss_snap(trig, st_r.loop, i_loop_acc); // RULE5 RULE10

        // Live byte, one cycle behind its inputs; not part of the snapshot
        st_nxt.fec = dss_fec_byte(i_qam_mode, i_fec_sync, i_trellis_sync, i_deint_work);
        st_nxt.fec_prev = i_fec_sync;

        ev = dss_events(trig, i_fec_sync, st_r.fec_prev);
        st_nxt.irq_stat = dss_sticky(stat_rd, st_r.irq_stat, ev);
        st_nxt.irq_mask = dss_mask_next(mask_wr, st_r.irq_mask, i_wb_dat);
        // From next state, so o_irq rises in the same edge as its status bit
        st_nxt.irq = dss_irq_level(st_nxt.irq_stat, st_nxt.irq_mask);

        // One wait state; unmapped words ack with zero
        st_nxt.ack = req;
        st_nxt.dat = dss_answer(req, i_wb_we, st_r.dat, rd_byte);
    end

    always_ff @(posedge i_ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r.pilot <= dss_pkg::VAL_RST;
            st_r.err <= dss_pkg::VAL_RST;
            st_r.loop <= dss_pkg::VAL_RST;
            st_r.fec <= dss_pkg::BYTE_RST;
            st_r.fec_prev <= dss_pkg::FEC_SEARCH;
            st_r.irq_stat <= dss_pkg::IRQ_RST;
            st_r.irq_mask <= dss_pkg::IRQ_RST;
            st_r.dat <= dss_pkg::DAT_RST;
            st_r.ack <= 1'b0;
            st_r.irq <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_wb_dat = st_r.dat;
    assign o_wb_ack = st_r.ack;
    assign o_irq = st_r.irq;

endmodule : dss_status_regs

//--- test/dss_status_regs_monitor.sv
// Purpose: Port-level checks of the status snapshot bank.
// Assumes: One clock domain, reads answered one cycle after the request edge.
// Notes: Keeps its own copy of the snapshot to judge read data.
`timescale 1ns/1ps
module dss_status_regs_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [dss_pkg::ADR_W-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [dss_pkg::DAT_W-1:0] i_wb_dat,
    input wire logic [dss_pkg::DAT_W-1:0] o_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_qam_mode,
    input wire logic [dss_pkg::VAL_W-1:0] i_pilot_acc,
    input wire logic [dss_pkg::VAL_W-1:0] i_avg_err,
    input wire logic [dss_pkg::VAL_W-1:0] i_loop_acc,
    input wire logic [1:0] i_fec_sync,
    input wire logic [1:0] i_trellis_sync,
    input wire logic [3:0] i_deint_work
);
    logic req;
    logic [59:0] cap_r;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    assign req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_r <= '0;
        end else if (req && i_wb_we && i_wb_adr[9:2] == dss_pkg::IDX_SNAP_CTRL && i_wb_sel[0]
                     && i_wb_dat[0]) begin
            cap_r <= {i_loop_acc, i_avg_err, i_pilot_acc};
        end
    end
    sequence s_rd(logic [7:0] idx);
        req && !i_wb_we && i_wb_adr[9:2] == idx;
    endsequence
    property p_pilot_top;
        s_rd(dss_pkg::IDX_PILOT_TOP) |=> o_wb_ack && o_wb_dat == {28'h000_0000, cap_r[19:16]};
    endproperty
    a_pilot_top: assert property (p_pilot_top) else $error("pilot top byte wrong");
    property p_pilot_mid;
        s_rd(dss_pkg::IDX_PILOT_MID) |=> o_wb_ack && o_wb_dat[7:0] == cap_r[15:8];
    endproperty
    a_pilot_mid: assert property (p_pilot_mid) else $error("pilot mid byte wrong");
    property p_err_low;
        s_rd(dss_pkg::IDX_ERR_LOW) |=> o_wb_ack && o_wb_dat[7:0] == cap_r[27:20];
    endproperty
    a_err_low: assert property (p_err_low) else $error("error low byte wrong");
    property p_loop_mid;
        s_rd(dss_pkg::IDX_LOOP_MID) |=> o_wb_ack && o_wb_dat[7:0] == cap_r[55:48];
    endproperty
    a_loop_mid: assert property (p_loop_mid) else $error("loop mid byte wrong");
    property p_err_top;
        s_rd(dss_pkg::IDX_ERR_TOP) |=> o_wb_dat[7:4] == 4'h0 && o_wb_dat[3:0] == cap_r[39:36];
    endproperty
    a_err_top: assert property (p_err_top) else $error("error top byte wrong");
    property p_fec_vsb;
        s_rd(dss_pkg::IDX_FEC_SYNC) ##0 (!i_qam_mode && $stable(i_fec_sync) && $stable(i_qam_mode))
        |=> o_wb_dat[7:0] == {6'h00, $past(i_fec_sync)};
    endproperty
    a_fec_vsb: assert property (p_fec_vsb) else $error("vsb fec byte wrong");
    property p_fec_qam;
        s_rd(dss_pkg::IDX_FEC_SYNC) ##0 (i_qam_mode && $stable(i_trellis_sync)
        && $stable(i_qam_mode)) |=> o_wb_dat[7:6] == $past(i_trellis_sync);
    endproperty
    a_fec_qam: assert property (p_fec_qam) else $error("trellis field wrong");
    property p_deint;
        s_rd(dss_pkg::IDX_FEC_SYNC) ##0 (i_qam_mode && $stable(i_deint_work)
        && $stable(i_qam_mode)) |=> o_wb_dat[5:2] == $past(i_deint_work);
    endproperty
    a_deint: assert property (p_deint) else $error("deinterleaver field wrong");
endmodule : dss_status_regs_monitor
bind dss_status_regs dss_status_regs_monitor dss_status_regs_monitor_i (.i_ref_clk, .i_rst_b,
    .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .i_qam_mode, .i_pilot_acc, .i_avg_err, .i_loop_acc, .i_fec_sync, .i_trellis_sync,
    .i_deint_work);

//--- test/dss_status_regs_tb.sv
// Purpose: Self-checking bench for the status snapshot bank.
// Assumes: Bench is the only bus master.
// Notes: Expected bytes are built from the driven loop values.
`timescale 1ns/1ps
module dss_status_regs_tb;
    logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0, qam = 1'b0, ack, irq;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [19:0] pil = 20'h0_0000, err = 20'h0_0000, lp = 20'h0_0000;
    logic [1:0] fec = 2'h0, trl = 2'h0;
    logic [3:0] dw = 4'h0;
    int fails = 0, checked = 0, cycles = 0;
    dss_status_regs dss_status_regs_i (.i_ref_clk(clk), .i_rst_b(rst_b), .i_wb_cyc(cyc),
        .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .i_qam_mode(qam), .i_pilot_acc(pil),
        .i_avg_err(err), .i_loop_acc(lp), .i_fec_sync(fec), .i_trellis_sync(trl),
        .i_deint_work(dw));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Request held until ack is sampled, then released for a cycle
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic [31:0] e);
        @(posedge clk);
        cyc <= 1'b1; we <= w; adr <= {idx, 2'b00}; wdat <= {24'h00_0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        if (!w) chk($sformatf("reg %h", idx), e, rdat);
        cyc <= 1'b0;
    endtask : wb
    task automatic t_snapshot();
        logic [59:0] v;
        logic [7:0] b [3];
        b = '{dss_pkg::IDX_PILOT_LOW, dss_pkg::IDX_ERR_LOW, dss_pkg::IDX_LOOP_LOW};
        v = {20'hF_0B48, 20'h3_96E7, 20'hA_5C31};
        {lp, err, pil} <= v;
        wb(1'b1, dss_pkg::IDX_SNAP_CTRL, 8'h01, '0);
        {lp, err, pil} <= ~v;
        wb(1'b1, dss_pkg::IDX_SNAP_CTRL, 8'h00, '0);
        wb(1'b0, 8'h7F, 8'h00, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 3; j++) begin
                wb(1'b0, b[k] + 8'(j), 8'h00, j == 2 ? {28'h000_0000, v[20*k+16 +: 4]}
                : {24'h00_0000, v[20*k+8*j +: 8]});
            end
        end
    endtask : t_snapshot
    task automatic t_fec();
        logic [1:0] f, t;
        logic [3:0] d;
        for (int m = 0; m < 2; m++) begin
            for (int c = 0; c < 3; c++) begin
                f = c == 2 ? 2'h3 : 2'(c);
                t = c == 0 ? 2'h0 : 2'(c + 1);
                d = 4'(5 * c + 3 + m);
                qam <= m[0]; fec <= f; trl <= t; dw <= d;
                @(posedge clk);
                wb(1'b0, dss_pkg::IDX_FEC_SYNC, 8'h00,
                   m ? {24'h00_0000, t, d, f} : {24'h00_0000, 6'h00, f});
            end
        end
    endtask : t_fec
    task automatic t_irq();
        chk("masked irq", 32'h0000_0000, {31'h0000_0000, irq});
        wb(1'b0, dss_pkg::IDX_IRQ_STAT, 8'h00, 32'h0000_0007);
        wb(1'b1, dss_pkg::IDX_IRQ_MASK, 8'h02, '0);
        fec <= 2'h0;
        @(posedge clk);
        fec <= 2'h1;
        for (int n = 0; n < 8 && irq !== 1'b1; n++) @(posedge clk);
        chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
        wb(1'b0, dss_pkg::IDX_IRQ_STAT, 8'h00, 32'h0000_0002);
        for (int n = 0; n < 8 && irq !== 1'b0; n++) @(posedge clk);
        chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
    endtask : t_irq
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_snapshot();
        t_fec();
        t_irq();
        wrap_up();
    end
endmodule : dss_status_regs_tb
